// >>> src/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_INPUT_CFG  = 8'h02;
  localparam logic [7:0] OFS_CHANNEL    = 8'h03;
  localparam logic [7:0] OFS_DATA_LOW   = 8'h04;
  localparam logic [7:0] OFS_DATA_MID   = 8'h05;
  localparam logic [7:0] OFS_DATA_HIGH  = 8'h06;
  localparam logic [7:0] OFS_CTRL_MAIN  = 8'h07;
  localparam logic [7:0] OFS_CTRL_AUX   = 8'h08;
  localparam logic [7:0] OFS_CLKDIV     = 8'h09;
  localparam logic [7:0] OFS_TRIM       = 8'h0a;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_INPUT_CFG  = 8'h00;
  localparam logic [7:0] RST_CHANNEL    = 8'h00;
  localparam logic [7:0] RST_CTRL_MAIN  = 8'h20;
  localparam logic [7:0] RST_CTRL_AUX   = 8'h00;
  localparam logic [7:0] RST_CLKDIV     = 8'h00;
  localparam logic [7:0] RST_TRIM       = 8'he4;

  // ---------------------------------------------------------------
  // Field positions and masks of readable bits
  // ---------------------------------------------------------------
  localparam int         BIT_SHORT      = 6;
  localparam int         BIT_RESET      = 7;
  localparam int         BIT_SLEEP      = 6;
  localparam int         BIT_POWER_OFF  = 5;
  localparam int         BIT_REF_PAIR   = 0;
  localparam int         BIT_BUF_NEG    = 4;
  localparam int         BIT_BUF_POS    = 3;
  localparam int         BIT_HOLD       = 2;
  localparam int         BIT_DONE       = 1;
  localparam logic [7:0] MASK_INPUT_CFG = 8'h7e;
  localparam logic [7:0] MASK_CHANNEL   = 8'h3f;
  localparam logic [7:0] MASK_CTRL_AUX  = 8'hfe;
  localparam logic [7:0] MASK_CLKDIV    = 8'h1f;

  // ---------------------------------------------------------------
  // Codes and ratios
  // ---------------------------------------------------------------
  localparam logic [4:0] CLKDIV_BYPASS  = 5'h1f;
  localparam logic [2:0] MODDIV_CODE_12 = 3'h2;
  localparam logic [4:0] MODDIV_N30     = 5'h1e;
  localparam logic [4:0] MODDIV_N12     = 5'h0c;
  localparam logic [3:0] OSR_CODE_16K   = 4'h1;

  typedef enum logic [1:0] {
    MODE_POWER_DOWN = 2'b00,
    MODE_SLEEP      = 2'b01,
    MODE_RESET      = 2'b10,
    MODE_NORMAL     = 2'b11
  } op_mode_t;

  // Modulator divide ratio N; reserved codes fall back to 30.
  function automatic logic [4:0] modulator_ratio(input logic [2:0] code);
    modulator_ratio = (code == MODDIV_CODE_12) ? MODDIV_N12 : MODDIV_N30;
  endfunction

  // Input selector decode; reserved codes give no route.
  function automatic logic [7:0] route_onehot(input logic [2:0] code,
                                              input logic [7:0] legal);
    route_onehot = legal[code] ? (8'h01 << code) : 8'h00;
  endfunction

  localparam logic [7:0] LEGAL_NEG = 8'hf3;
  localparam logic [7:0] LEGAL_POS = 8'hd3;

endpackage
`default_nettype wire

// >>> src/clock_enable_gen.sv
`timescale 1ns/10ps
`default_nettype none
module clock_enable_gen
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       enable,
  input  wire logic [4:0] master_clock_divider,
  input  wire logic [2:0] modulator_divider_select,
  // Enables
  output logic            mclk_tick,
  output logic            mod_tick
);

  logic [5:0] mclk_count;
  logic [4:0] mod_count;
  logic       bypass;
  logic [5:0] mclk_last;
  logic [4:0] mod_last;

  // ---------------------------------------------------------------
  // Master clock divider
  // ---------------------------------------------------------------
  // R10 master clock ratio
  assign bypass    = (master_clock_divider == CLKDIV_BYPASS);
  assign mclk_last = {master_clock_divider, 1'b1};
  assign mclk_tick = enable & (bypass | (mclk_count == mclk_last));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mclk_count <= 6'h00;
    end else if (!enable || mclk_tick) begin
      mclk_count <= 6'h00;
    end else begin
      mclk_count <= mclk_count + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // Modulator clock divider
  // ---------------------------------------------------------------
  // R09 modulator divide by N
  assign mod_last = modulator_ratio(modulator_divider_select) - 5'h01;
  assign mod_tick = mclk_tick & (mod_count >= mod_last);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mod_count <= 5'h00;
    end else if (!enable || mod_tick) begin
      mod_count <= 5'h00;
    end else if (mclk_tick) begin
      mod_count <= mod_count + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_bypass_every_cycle;
    @(posedge clk) disable iff (!arst_n)
      (enable && bypass && $stable(master_clock_divider)) |-> mclk_tick;
  endproperty
  a_bypass_every_cycle: assert property (p_bypass_every_cycle) // R10
    else $error("Bypass code did not pass every cycle.");

  property p_div_spacing;
    @(posedge clk) disable iff (!arst_n)
      (mclk_tick && !bypass && master_clock_divider == 5'h00 && enable)
      ##1 (enable && master_clock_divider == 5'h00) |-> !mclk_tick;
  endproperty
  a_div_spacing: assert property (p_div_spacing) // R10
    else $error("Master clock tick came too early.");

endmodule
`default_nettype wire

// >>> src/conversion_counter.sv
`timescale 1ns/10ps
`default_nettype none
module conversion_counter #(
  parameter int OSR_WIDTH = 17
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // Control
  input  wire logic                 clear,
  input  wire logic                 run,
  input  wire logic                 mod_tick,
  input  wire logic [OSR_WIDTH-1:0] osr,
  // Status
  output logic                      done
);

  logic [OSR_WIDTH-1:0] count;
  logic [OSR_WIDTH-1:0] last;

  // ---------------------------------------------------------------
  // Oversampling counter
  // ---------------------------------------------------------------
  // R08 oversampling count
  assign last = osr - {{(OSR_WIDTH-1){1'b0}}, 1'b1};
  assign done = run & mod_tick & (count >= last);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else if (clear || done) begin
      count <= '0;
    end else if (run && mod_tick) begin
      count <= count + {{(OSR_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  property p_done_needs_run;
    @(posedge clk) disable iff (!arst_n)
      done |-> (run && !clear && count >= last);
  endproperty
  a_done_needs_run: assert property (p_done_needs_run) // R14
    else $error("Conversion ended without running.");

endmodule
`default_nettype wire

// >>> src/delta_sigma_adc_control.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R01 - Input config bit 6 shorts the two selected input terminals together.
// R02 - Offset field bits 3..1 gives zero or signed quarter reference steps.
// R03 - Negative selector bits 5..3 routes second input; 010, 011 reserved.
// R04 - Positive selector bits 2..0 routes first input; 010, 011, 101 reserved.
// R05 - Host pairs single-ended inputs with the common-mode reference.
// R06 - Host pairs temperature sensor negative and positive outputs.
// R07 - Power-off bit overrides sleep and reset; resets to one.
// R08 - Oversampling field sets ratio; code 0001 gives 16384.
// R09 - Divider field sets modulator clock to master clock over 30 or 12.
// R10 - Clock divider field divides by 2(k+1); all-ones passes clock.
// R11 - Done flag set on completion, held until software writes zero.
// R12 - Host keeps the trim register at 1110 0111.
// R13 - Unimplemented bits of config, channel and divider read zero.
// R14 - Conversion starts after reset bit pulses; high holds filter reset.
// R15 - Sleep bit stops the modulator while powered on.
// R16 - Data hold keeps latest result; done flag not set meanwhile, but a write of zero still clears it.
// R17 - Reference pair bit one selects the external reference pins.
// R18 - Cross-connect field is stored and driven to the switch matrix.
module delta_sigma_adc_control
  import adc_ctrl_pkg::*;
#(
  parameter int OSR_WIDTH = 17,
  parameter int OSR_16K   = 16384,
  parameter int OSR_OTHER = 16384
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  // Filter result
  input  wire logic [23:0] filter_result,
  // Input switch matrix
  output logic             input_short_enable,
  output logic [1:0]       input_cross_select,
  output logic [2:0]       input_offset_select,
  output logic             offset_negative,
  output logic [1:0]       offset_quarters,
  output logic [7:0]       negative_route,
  output logic [7:0]       positive_route,
  output logic             reference_pair_select,
  output logic             neg_buffer_enable,
  output logic             pos_buffer_enable,
  output logic [7:0]       trim_value,
  // Converter state
  output op_mode_t         op_mode,
  output logic             converter_powered,
  output logic             modulator_run,
  output logic             filter_reset,
  output logic             conversion_done
);

  import adc_ctrl_pkg::*;

  logic [7:0]           input_cfg;
  logic [7:0]           channel;
  logic [7:0]           ctrl_main;
  logic [7:0]           ctrl_aux;
  logic [7:0]           clkdiv;
  logic [7:0]           trim;
  logic [23:0]          result;
  logic                 armed;
  logic                 eoc;

  wire                  wr_cfg     = reg_wr && reg_addr == OFS_INPUT_CFG;
  wire                  wr_chan    = reg_wr && reg_addr == OFS_CHANNEL;
  wire                  wr_main    = reg_wr && reg_addr == OFS_CTRL_MAIN;
  wire                  wr_aux     = reg_wr && reg_addr == OFS_CTRL_AUX;
  wire                  wr_div     = reg_wr && reg_addr == OFS_CLKDIV;
  wire                  wr_trim    = reg_wr && reg_addr == OFS_TRIM;
  wire                  power_off  = ctrl_main[BIT_POWER_OFF];
  wire                  sleep      = ctrl_main[BIT_SLEEP];
  wire                  rst_bit    = ctrl_main[BIT_RESET];
  wire                  hold       = ctrl_aux[BIT_HOLD];
  wire                  eoc_clear  = wr_aux && !reg_wdata[BIT_DONE];
  wire [2:0]            offset_cd  = input_cfg[3:1];
  wire [3:0]            osr_code   = ctrl_main[4:1];
  wire                  mclk_tick;
  wire                  mod_tick;
  wire                  done;
  wire                  run;
  wire                  clear;
  wire [OSR_WIDTH-1:0]  osr;
  logic [7:0]           next_rdata;
  op_mode_t             next_mode;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  // R13 unimplemented bits zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      input_cfg <= RST_INPUT_CFG;
      channel   <= RST_CHANNEL;
      clkdiv    <= RST_CLKDIV;
      trim      <= RST_TRIM;
    end else begin
      if (wr_cfg) input_cfg <= reg_wdata & MASK_INPUT_CFG;
      if (wr_chan) channel <= reg_wdata & MASK_CHANNEL;
      if (wr_div) clkdiv <= reg_wdata & MASK_CLKDIV;
      if (wr_trim) trim <= reg_wdata;
    end
  end

  // R07 power-off resets high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_main <= RST_CTRL_MAIN;
    end else if (wr_main) begin
      ctrl_main <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_aux <= RST_CTRL_AUX;
    end else if (wr_aux) begin
      ctrl_aux <= reg_wdata & MASK_CTRL_AUX & ~(8'h01 << BIT_DONE);
    end
  end

  // ---------------------------------------------------------------
  // Operating mode
  // ---------------------------------------------------------------
  // R07 power-off overrides
  // R15 sleep stops modulator
  assign next_mode = power_off ? MODE_POWER_DOWN :
                     sleep     ? MODE_SLEEP      :
                     rst_bit   ? MODE_RESET      : MODE_NORMAL;

  // R14 start after reset pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 1'b0;
    end else if (power_off) begin
      armed <= 1'b0;
    end else if (rst_bit) begin
      armed <= 1'b1;
    end
  end

  assign run   = armed && next_mode == MODE_NORMAL;
  assign clear = !armed || power_off || rst_bit;
  assign osr   = (osr_code == OSR_CODE_16K) ? OSR_WIDTH'(OSR_16K)
                                            : OSR_WIDTH'(OSR_OTHER);

  clock_enable_gen u_clock_enable_gen (
    .clk                      (clk),
    .arst_n                   (arst_n),
    .enable                   (!power_off),
    .master_clock_divider     (clkdiv[4:0]),
    .modulator_divider_select (ctrl_aux[7:5]),
    .mclk_tick                (mclk_tick),
    .mod_tick                 (mod_tick)
  );

  conversion_counter #(
    .OSR_WIDTH (OSR_WIDTH)
  ) u_conversion_counter (
    .clk      (clk),
    .arst_n   (arst_n),
    .clear    (clear),
    .run      (run),
    .mod_tick (mod_tick),
    .osr      (osr),
    .done     (done)
  );

  // ---------------------------------------------------------------
  // Result and done flag
  // ---------------------------------------------------------------
  // R16 hold freezes data
  // R11 sticky done, set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result <= 24'h000000;
      eoc    <= 1'b0;
    end else begin
      if (done && !hold) result <= filter_result;
      if (done && !hold) eoc <= 1'b1;
      else if (eoc_clear) eoc <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      OFS_INPUT_CFG: next_rdata = input_cfg;
      OFS_CHANNEL:   next_rdata = channel;
      OFS_DATA_LOW:  next_rdata = result[7:0];
      OFS_DATA_MID:  next_rdata = result[15:8];
      OFS_DATA_HIGH: next_rdata = result[23:16];
      OFS_CTRL_MAIN: next_rdata = ctrl_main;
      OFS_CTRL_AUX:  next_rdata = ctrl_aux | ({7'h00, eoc} << BIT_DONE);
      OFS_CLKDIV:    next_rdata = clkdiv;
      OFS_TRIM:      next_rdata = trim;
      default:       next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Analog control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      input_short_enable    <= 1'b0;
      input_cross_select    <= 2'b00;
      input_offset_select   <= 3'b000;
      offset_negative       <= 1'b0;
      offset_quarters       <= 2'b00;
      negative_route        <= 8'h00;
      positive_route        <= 8'h00;
      reference_pair_select <= 1'b0;
      neg_buffer_enable     <= 1'b0;
      pos_buffer_enable     <= 1'b0;
      trim_value            <= RST_TRIM;
      op_mode               <= MODE_POWER_DOWN;
    end else begin
      // R01 input short
      input_short_enable    <= input_cfg[BIT_SHORT];
      // R18 cross-connect drive
      input_cross_select    <= input_cfg[5:4];
      // R02 offset decode
      input_offset_select   <= offset_cd;
      offset_negative       <= offset_cd[2] && offset_cd[1:0] != 2'b00;
      offset_quarters       <= offset_cd[1:0];
      // R03 negative route
      negative_route        <= route_onehot(channel[5:3], LEGAL_NEG);
      // R04 positive route
      positive_route        <= route_onehot(channel[2:0], LEGAL_POS);
      // R17 reference pair
      reference_pair_select <= ctrl_main[BIT_REF_PAIR];
      neg_buffer_enable     <= ctrl_aux[BIT_BUF_NEG];
      pos_buffer_enable     <= ctrl_aux[BIT_BUF_POS];
      trim_value            <= trim;
      op_mode               <= next_mode;
    end
  end

  assign converter_powered = op_mode != MODE_POWER_DOWN;
  assign modulator_run     = op_mode == MODE_NORMAL || op_mode == MODE_RESET;
  assign filter_reset      = op_mode == MODE_RESET;
  assign conversion_done   = eoc;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_done_sets_flag;
    @(posedge clk) disable iff (!arst_n) (done && !hold) |=> eoc;
  endproperty
  a_done_sets_flag: assert property (p_done_sets_flag) // R11
    else $error("Done flag not set after conversion.");

  property p_flag_sticky;
    @(posedge clk) disable iff (!arst_n) (eoc && !eoc_clear) |=> eoc;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // R11
    else $error("Done flag dropped without a clear.");

  property p_hold_keeps_data;
    @(posedge clk) disable iff (!arst_n)
      hold |=> ($stable(result) && ($past(eoc) || !eoc));
  endproperty
  a_hold_keeps_data: assert property (p_hold_keeps_data) // R16
    else $error("Result or flag changed under hold.");

  property p_power_off_down;
    @(posedge clk) disable iff (!arst_n)
      power_off |=> (!converter_powered && !modulator_run);
  endproperty
  a_power_off_down: assert property (p_power_off_down) // R07
    else $error("Converter not powered down.");

  property p_sleep_stops;
    @(posedge clk) disable iff (!arst_n)
      (!power_off && sleep) |-> !done ##1 !modulator_run;
  endproperty
  a_sleep_stops: assert property (p_sleep_stops) // R15
    else $error("Modulator ran in sleep.");

  property p_reset_holds_filter;
    @(posedge clk) disable iff (!arst_n)
      (rst_bit && !power_off && !sleep) |=> filter_reset ##0 !done;
  endproperty
  a_reset_holds_filter: assert property (p_reset_holds_filter) // R14
    else $error("Filter not held in reset.");

  property p_channel_read_zero;
    @(posedge clk) disable iff (!arst_n)
      (reg_rd && reg_addr == OFS_CHANNEL) |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_channel_read_zero: assert property (p_channel_read_zero) // R13
    else $error("Unimplemented channel bits read nonzero.");

  property p_short_follows;
    @(posedge clk) disable iff (!arst_n)
      wr_cfg ##1 !wr_cfg |=> input_short_enable == $past(reg_wdata[6], 2);
  endproperty
  a_short_follows: assert property (p_short_follows) // R01
    else $error("Input short does not follow its bit.");

  property p_reserved_neg;
    @(posedge clk) disable iff (!arst_n)
      (channel[5:3] == 3'b010) |=> negative_route == 8'h00;
  endproperty
  a_reserved_neg: assert property (p_reserved_neg) // R03
    else $error("Reserved negative code routed.");

  c_flag_set: cover property (@(posedge clk) disable iff (!arst_n)
    !eoc ##1 eoc);
  c_hold_discard: cover property (@(posedge clk) disable iff (!arst_n)
    done && hold);
  c_start_pulse: cover property (@(posedge clk) disable iff (!arst_n)
    rst_bit ##[1:20] !rst_bit && run);

endmodule
`default_nettype wire

// >>> test/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model
  import adc_ctrl_pkg::*;
(
  // Clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  // Register strobes
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata
);
  import adc_ctrl_pkg::*;
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  // Released data shows its inverse.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  task automatic prepare();
    wr(OFS_TRIM, 8'he7);
    wr(OFS_CHANNEL, 8'h3f);
  endtask
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import adc_ctrl_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, negative_route, positive_route;
  logic reg_wr, reg_rd, input_short_enable, offset_negative, conversion_done;
  logic [23:0] filter_result = 24'h123456;
  logic [1:0] input_cross_select, offset_quarters;
  logic [2:0] input_offset_select;
  logic [7:0] trim_value;
  logic reference_pair_select, converter_powered, modulator_run, filter_reset;
  op_mode_t op_mode;
  int err_count = 0, compares = 0;
  always #2 clk = ~clk;
  delta_sigma_adc_control #(.OSR_OTHER(4)) i_dut (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .filter_result(filter_result), .input_short_enable(input_short_enable),
    .input_cross_select(input_cross_select),
    .input_offset_select(input_offset_select),
    .offset_negative(offset_negative), .offset_quarters(offset_quarters),
    .negative_route(negative_route), .positive_route(positive_route),
    .reference_pair_select(reference_pair_select),
    .neg_buffer_enable(), .pos_buffer_enable(), .trim_value(trim_value),
    .op_mode(op_mode), .converter_powered(converter_powered),
    .modulator_run(modulator_run), .filter_reset(filter_reset),
    .conversion_done(conversion_done));
  host_model i_host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  task automatic chk(input string nm, input logic [23:0] e,
                     input logic [23:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    chk($sformatf("reg_%h", a), e, d);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_done(input int lim, output int n);
    n = 0;
    while (conversion_done !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_reset();
    rdchk(OFS_INPUT_CFG, 8'h00);
    rdchk(OFS_CHANNEL, 8'h00);
    rdchk(OFS_CTRL_MAIN, 8'h20);
    rdchk(OFS_CTRL_AUX, 8'h00);
    rdchk(OFS_CLKDIV, 8'h00);
    rdchk(OFS_TRIM, 8'he4);
    rdchk(8'h0f, 8'h00);
    chk("mode", MODE_POWER_DOWN, op_mode);
    i_host.prepare();
    rdchk(OFS_TRIM, 8'he7);
    chk("trim", 8'he7, trim_value);
  endtask
  task automatic t_fields();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {1'b1, i[0], i[1:0], i[2:0], 1'b1};
      i_host.wr(OFS_INPUT_CFG, d);
      settle();
      rdchk(OFS_INPUT_CFG, d & 8'h7e);
      chk("short", i[0], input_short_enable);
      chk("cross", i[1:0], input_cross_select);
      chk("ofs", i[2:0], input_offset_select);
      chk("neg", i > 4, offset_negative);
      chk("quart", i[1:0], offset_quarters);
      i_host.wr(OFS_CHANNEL, {2'b11, i[2:0], i[2:0]});
      settle();
      rdchk(OFS_CHANNEL, {2'b00, i[2:0], i[2:0]});
      d = 8'hf3;
      chk("nroute", d[i] ? 8'h01 << i : 8'h00, negative_route);
      d = 8'hd3;
      chk("proute", d[i] ? 8'h01 << i : 8'h00, positive_route);
    end
  endtask
  task automatic t_modes();
    logic [7:0] mv [6] = '{8'h20, 8'he0, 8'h40, 8'h80, 8'h00, 8'h01};
    op_mode_t mm [6] = '{MODE_POWER_DOWN, MODE_POWER_DOWN, MODE_SLEEP,
                         MODE_RESET, MODE_NORMAL, MODE_NORMAL};
    for (int i = 0; i < 6; i++) begin
      i_host.wr(OFS_CTRL_MAIN, mv[i]);
      settle();
      chk("mode", mm[i], op_mode);
      chk("run", mm[i][1], modulator_run);
      chk("power", mm[i] != MODE_POWER_DOWN, converter_powered);
      chk("freset", mm[i] == MODE_RESET, filter_reset);
      chk("refsel", mv[i][0], reference_pair_select);
    end
  endtask
  task automatic conv(input logic [4:0] k, input int e);
    int n;
    i_host.wr(OFS_CLKDIV, {3'b111, k});
    rdchk(OFS_CLKDIV, {3'b000, k});
    i_host.wr(OFS_CTRL_MAIN, 8'h84);
    i_host.wr(OFS_CTRL_AUX, 8'h40);
    i_host.wr(OFS_CTRL_MAIN, 8'h04);
    wait_done(400, n);
    compares++;
    if (n < e - e / 4 + 2 || n > e + 1) begin
      err_count++;
      $display("[ERR] conv_time expected %0d seen %0d", e, n);
    end
  endtask
  task automatic t_conv();
    int n;
    i_host.wr(OFS_CTRL_AUX, 8'h40);
    conv(5'h1f, 48);
    rdchk(OFS_DATA_LOW, 8'h56);
    rdchk(OFS_DATA_MID, 8'h34);
    rdchk(OFS_DATA_HIGH, 8'h12);
    rdchk(OFS_CTRL_AUX, 8'h42);
    i_host.wr(OFS_CTRL_AUX, 8'h46);
    i_host.wr(OFS_CTRL_AUX, 8'h44);
    settle();
    chk("done_clr", 1'b0, conversion_done);
    @(posedge clk) filter_result <= 24'habcdef;
    repeat (150) @(posedge clk);
    chk("done_hold", 1'b0, conversion_done);
    rdchk(OFS_DATA_LOW, 8'h56);
    i_host.wr(OFS_CTRL_AUX, 8'h46);
    settle();
    chk("done_w1", 1'b0, conversion_done);
    i_host.wr(OFS_CTRL_AUX, 8'h42);
    wait_done(200, n);
    rdchk(OFS_DATA_HIGH, 8'hab);
    conv(5'h00, 96);
    i_host.wr(OFS_CTRL_MAIN, 8'h24);
    i_host.wr(OFS_CTRL_MAIN, 8'h04);
    i_host.wr(OFS_CTRL_AUX, 8'h40);
    repeat (150) @(posedge clk);
    chk("disarm", 1'b0, conversion_done);
  endtask
  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_fields();
    t_modes();
    t_conv();
    complete_run();
  end
endmodule
`default_nettype wire
